// ---- design/pbmc_pkg.sv ----
package pbmc_pkg;

  // register port geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [4:0] OFF_BASIC_MODE_CONTROL = 5'h00;
  localparam logic [4:0] OFF_LINK_STATUS        = 5'h01;
  localparam logic [4:0] OFF_RX_ERROR_COUNT     = 5'h02;

  // basic_mode_control field positions
  localparam int BIT_SW_RESET   = 15;
  localparam int BIT_LOOPBACK   = 14;
  localparam int BIT_SPEED_SEL  = 13;
  localparam int BIT_ANEG_EN    = 12;
  localparam int BIT_POWER_DOWN = 11;
  localparam int BIT_ISOLATE    = 10;
  localparam int BIT_DUPLEX_SEL = 8;

  // reset values of the non-strapped control bits
  localparam logic RST_SW_RESET   = 1'b0;
  localparam logic RST_LOOPBACK   = 1'b0;
  localparam logic RST_POWER_DOWN = 1'b0;
  localparam logic RST_ISOLATE    = 1'b0;

  // link_status field positions and the permanent pattern
  localparam int         BIT_LINK_LL   = 2;
  localparam int         BIT_FAULT_LH  = 1;
  localparam logic [15:0] STS_FIXED    = 16'h4000;
  localparam logic        RST_LINK_LL  = 1'b0;
  localparam logic        RST_FAULT_LH = 1'b0;

  // clear-on-read counter
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [15:0] CNT_ONE   = 16'h0001;

  // software reset duration
  localparam int CLK_PERIOD_NS   = 40;
  localparam int SW_RESET_NS     = 1000;
  localparam int SW_RESET_CYCLES =
    (SW_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SW_RESET_LAST = 8'(SW_RESET_CYCLES - 1);
  localparam logic [7:0] CNT8_ZERO     = 8'h00;
  localparam logic [7:0] CNT8_ONE      = 8'h01;

  // software reset sequencer states
  typedef enum logic [2:0] {
    PBMC_SR_IDLE = 3'b001,
    PBMC_SR_RUN  = 3'b010,
    PBMC_SR_DONE = 3'b100
  } pbmc_sr_state_t;

  // nibble-wide media independent data with its qualifier
  typedef struct packed {
    logic [3:0] data;
    logic       valid;
  } pbmc_mii_t;

  localparam pbmc_mii_t MII_IDLE = '{data: 4'h0, valid: 1'b0};

endpackage

// ---- design/pbmc_swrst.sv ----
`timescale 1ns/10ps
module pbmc_swrst
  import pbmc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy_r,
  output logic      done_r
);

  pbmc_sr_state_t state_r;
  pbmc_sr_state_t state_nxt;
  logic [7:0]     cnt_r;

  // next state; a start while busy is ignored so nothing aborts the run
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PBMC_SR_IDLE: begin
        if (start) begin
          state_nxt = PBMC_SR_RUN;
        end
      end
      PBMC_SR_RUN: begin
        if (cnt_r == SW_RESET_LAST) begin
          state_nxt = PBMC_SR_DONE;
        end
      end
      PBMC_SR_DONE: begin
        state_nxt = PBMC_SR_IDLE;
      end
      default: begin
        state_nxt = PBMC_SR_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PBMC_SR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // cycle counter for the reset duration
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= CNT8_ZERO;
    end else if (state_r == PBMC_SR_RUN) begin
      cnt_r <= cnt_r + CNT8_ONE;
    end else begin
      cnt_r <= CNT8_ZERO;
    end
  end

  // busy covers the run, done is a one-cycle completion pulse
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt == PBMC_SR_RUN);
      done_r <= (state_nxt == PBMC_SR_DONE);
    end
  end

endmodule

// ---- design/pbmc_top.sv ----
// Behaviour
// - clear-on-read bits return value then clear
// - latched-low bit holds low until read
// - latched-high bit holds high until read
// - permanent read-only bits ignore writes
// - bit 15 starts reset, reads one, self-clears
// - software reset reloads all strap values
// - loopback bit routes transmit onto receive
// - bit 13 picks 100 or 10 Mb/s
// - auto-negotiation on ignores bits 8, 13
// - auto-negotiation strap, forced off for fiber
// - power-down bit stops PHY, registers stay
// - power-down is bit OR pin; pin sets bit
// - isolate bit cuts MII, management still works
// - bit 8 picks full or half duplex
`timescale 1ns/10ps
module pbmc_top
  import pbmc_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata_r,
  input  wire logic              strap_speed_100,
  input  wire logic              strap_full_duplex,
  input  wire logic              strap_aneg_enable,
  input  wire logic              fiber_mode_enable,
  input  wire logic              power_down_pin_n,
  input  wire logic              aneg_speed_100,
  input  wire logic              aneg_full_duplex,
  input  wire logic              link_up,
  input  wire logic              fault_event,
  input  wire logic              rx_error_event,
  input  wire pbmc_mii_t         mii_tx,
  output pbmc_mii_t              mii_rx_r,
  input  wire pbmc_mii_t         line_rx,
  output pbmc_mii_t              line_tx_r,
  output logic                   phy_power_down_r,
  output logic                   mii_isolate_r,
  output logic                   loopback_active_r,
  output logic                   link_speed_100_r,
  output logic                   link_full_duplex_r,
  output logic                   aneg_active_r,
  output logic                   core_reset_r
);

  logic        rst_meta_r;
  logic        rst_sync_r;
  logic        rst_n;
  logic        strap_done_r;
  logic        load_straps;
  logic        sr_busy;
  logic        sr_done;
  logic        sw_reset_r;
  logic        loopback_r;
  logic        speed_sel_r;
  logic        aneg_en_r;
  logic        power_down_r;
  logic        isolate_r;
  logic        duplex_sel_r;
  logic        link_ll_r;
  logic        fault_lh_r;
  logic [15:0] rx_err_cnt_r;
  logic        wr_ctrl;
  logic        rd_status;
  logic        rd_count;
  logic        sr_start;
  logic        pd_pin_active;
  logic        pd_effective;
  logic [15:0] ctrl_view;
  logic [15:0] status_view;
  logic [15:0] rdata_nxt;

  // reset release through two flops; the async edge still acts at once
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n = rst_sync_r;

  // straps are caught on the first clock after release, never by reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_r <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
    end
  end

  // a software reset ends with the same strap capture as a hardware one
  assign load_straps = !strap_done_r || sr_done;

  // register port decode
  assign wr_ctrl   = reg_wr && (reg_addr == OFF_BASIC_MODE_CONTROL);
  assign rd_status = reg_rd && (reg_addr == OFF_LINK_STATUS);
  assign rd_count  = reg_rd && (reg_addr == OFF_RX_ERROR_COUNT);

  // writes are held off while the reset runs so it cannot be cut short
  assign sr_start = wr_ctrl && reg_wdata[BIT_SW_RESET] && !sw_reset_r;

  assign pd_pin_active = !power_down_pin_n;
  assign pd_effective  = power_down_r || pd_pin_active;

  pbmc_swrst u_swrst (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (sr_start),
    .busy_r  (sr_busy),
    .done_r  (sr_done)
  );

  // reset bit: one from the accepting write until the run completes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_reset_r <= RST_SW_RESET;
    end else if (sr_start) begin
      sw_reset_r <= 1'b1;
    end else if (sr_done) begin
      sw_reset_r <= 1'b0;
    end
  end

  // plain read-write control bits; reset run returns them to defaults
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      loopback_r <= RST_LOOPBACK;
      isolate_r  <= RST_ISOLATE;
    end else if (sr_done) begin
      loopback_r <= RST_LOOPBACK;
      isolate_r  <= RST_ISOLATE;
    end else if (wr_ctrl && !sw_reset_r) begin
      loopback_r <= reg_wdata[BIT_LOOPBACK];
      isolate_r  <= reg_wdata[BIT_ISOLATE];
    end
  end

  // power-down bit; the pin sets it and wins over any write or reload
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_down_r <= RST_POWER_DOWN;
    end else if (pd_pin_active) begin
      power_down_r <= 1'b1;
    end else if (sr_done) begin
      power_down_r <= RST_POWER_DOWN;
    end else if (wr_ctrl && !sw_reset_r) begin
      power_down_r <= reg_wdata[BIT_POWER_DOWN];
    end
  end

  // strap-derived bits: speed, duplex and auto-negotiation enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_sel_r  <= 1'b0;
      duplex_sel_r <= 1'b0;
      aneg_en_r    <= 1'b0;
    end else if (load_straps) begin
      speed_sel_r  <= strap_speed_100;
      duplex_sel_r <= strap_full_duplex;
      aneg_en_r    <= strap_aneg_enable && !fiber_mode_enable;
    end else if (wr_ctrl && !sw_reset_r) begin
      speed_sel_r  <= reg_wdata[BIT_SPEED_SEL];
      duplex_sel_r <= reg_wdata[BIT_DUPLEX_SEL];
      aneg_en_r    <= reg_wdata[BIT_ANEG_EN];
    end
  end

  // latched-low link bit; a drop in the read cycle keeps it low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_ll_r <= RST_LINK_LL;
    end else if (!link_up) begin
      link_ll_r <= 1'b0;
    end else if (rd_status) begin
      link_ll_r <= 1'b1;
    end
  end

  // latched-high fault bit; an event in the read cycle keeps it high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_lh_r <= RST_FAULT_LH;
    end else if (fault_event) begin
      fault_lh_r <= 1'b1;
    end else if (rd_status) begin
      fault_lh_r <= 1'b0;
    end
  end

  // clear-on-read error counter; it saturates rather than wrapping
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_err_cnt_r <= CNT_RESET;
    end else if (rd_count) begin
      rx_err_cnt_r <= rx_error_event ? CNT_ONE : CNT_RESET;
    end else if (rx_error_event && (rx_err_cnt_r != CNT_MAX)) begin
      rx_err_cnt_r <= rx_err_cnt_r + CNT_ONE;
    end
  end

  // control register as read back; unused bits read zero
  always_comb begin
    ctrl_view                 = 16'h0000;
    ctrl_view[BIT_SW_RESET]   = sw_reset_r;
    ctrl_view[BIT_LOOPBACK]   = loopback_r;
    ctrl_view[BIT_SPEED_SEL]  = speed_sel_r;
    ctrl_view[BIT_ANEG_EN]    = aneg_en_r;
    ctrl_view[BIT_POWER_DOWN] = power_down_r;
    ctrl_view[BIT_ISOLATE]    = isolate_r;
    ctrl_view[BIT_DUPLEX_SEL] = duplex_sel_r;
  end

  // status register; the permanent pattern has no storage to write
  always_comb begin
    status_view               = STS_FIXED;
    status_view[BIT_LINK_LL]  = link_ll_r;
    status_view[BIT_FAULT_LH] = fault_lh_r;
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    rdata_nxt = 16'h0000;
    case (reg_addr)
      OFF_BASIC_MODE_CONTROL: begin
        rdata_nxt = ctrl_view;
      end
      OFF_LINK_STATUS: begin
        rdata_nxt = status_view;
      end
      OFF_RX_ERROR_COUNT: begin
        rdata_nxt = rx_err_cnt_r;
      end
      default: begin
        rdata_nxt = 16'h0000;
      end
    endcase
  end

  // read data stands one cycle, zero otherwise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata_r <= rdata_nxt;
    end else begin
      reg_rdata_r <= 16'h0000;
    end
  end

  // effective speed; the negotiated result overrides the manual bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_speed_100_r <= 1'b0;
    end else if (aneg_en_r) begin
      link_speed_100_r <= aneg_speed_100;
    end else begin
      link_speed_100_r <= speed_sel_r;
    end
  end

  // effective duplex; bit 8 only counts with negotiation off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_full_duplex_r <= 1'b0;
    end else if (aneg_en_r) begin
      link_full_duplex_r <= aneg_full_duplex;
    end else begin
      link_full_duplex_r <= duplex_sel_r;
    end
  end

  // negotiation state as seen by the PHY core
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aneg_active_r <= 1'b0;
    end else begin
      aneg_active_r <= aneg_en_r;
    end
  end

  // power-down toward the PHY core, one cycle behind the request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phy_power_down_r <= 1'b0;
    end else begin
      phy_power_down_r <= pd_effective;
    end
  end

  // isolation toward the MII; management access is never cut off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mii_isolate_r <= 1'b0;
    end else begin
      mii_isolate_r <= isolate_r;
    end
  end

  // loopback select toward the PHY core
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      loopback_active_r <= 1'b0;
    end else begin
      loopback_active_r <= loopback_r;
    end
  end

  // core reset; held through hardware reset so the core starts clean
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_reset_r <= 1'b1;
    end else begin
      core_reset_r <= sr_busy;
    end
  end

  // receive side toward the MAC; isolation and power-down silence it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mii_rx_r <= MII_IDLE;
    end else if (pd_effective || isolate_r || sr_busy) begin
      mii_rx_r <= MII_IDLE;
    end else if (loopback_r) begin
      mii_rx_r <= mii_tx;
    end else begin
      mii_rx_r <= line_rx;
    end
  end

  // transmit side toward the line; loopback keeps frames off the wire
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_tx_r <= MII_IDLE;
    end else if (pd_effective || isolate_r || loopback_r || sr_busy) begin
      line_tx_r <= MII_IDLE;
    end else begin
      line_tx_r <= mii_tx;
    end
  end

endmodule

// ---- tb/pbmc_properties.sv ----
`timescale 1ns/10ps
module pbmc_properties
  import pbmc_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              fiber_mode_enable,
  input wire logic              power_down_pin_n,
  input wire pbmc_mii_t         mii_tx,
  input wire pbmc_mii_t         mii_rx_r,
  input wire logic              phy_power_down_r,
  input wire logic              mii_isolate_r,
  input wire logic              loopback_active_r,
  input wire logic              aneg_active_r,
  input wire logic              core_reset_r
);
  localparam int RUN_LO = SW_RESET_CYCLES - 1;
  localparam int RUN_HI = SW_RESET_CYCLES + 2;

  logic [2:0] up_r;
  logic [5:0] run_r;
  logic       live;

  // the internal reset lags nrst by two flops, so wait four edges
  assign live = (up_r == 3'h4);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      up_r <= 3'h0;
    else if (!live)
      up_r <= up_r + 3'h1;
  end

  // length of the current software reset, saturating
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      run_r <= 6'h00;
    else if (!core_reset_r)
      run_r <= 6'h00;
    else if (run_r != 6'h3f)
      run_r <= run_r + 6'h01;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  sequence swr_req;
    live && reg_wr && reg_addr == OFF_BASIC_MODE_CONTROL
      && reg_wdata[BIT_SW_RESET] && !core_reset_r;
  endsequence

  sequence loop_on;
    loopback_active_r && !phy_power_down_r && !mii_isolate_r
      && !core_reset_r;
  endsequence

  a_swrst_start: assert property (swr_req |-> ##2 core_reset_r)
    else $error("software reset did not start");
  a_swrst_ends: assert property (
    $rose(core_reset_r) |-> ##[1:40] !core_reset_r)
    else $error("software reset never finished");
  a_swrst_length: assert property (
    live && $fell(core_reset_r) |-> run_r >= RUN_LO && run_r <= RUN_HI)
    else $error("software reset had the wrong length");
  a_fiber_aneg: assert property (
    live && fiber_mode_enable && $fell(core_reset_r) |=> !aneg_active_r)
    else $error("auto-negotiation on in fiber mode");
  a_pin_power: assert property (
    live && !power_down_pin_n |=> phy_power_down_r)
    else $error("power-down pin ignored");
  a_pd_quiet: assert property (
    phy_power_down_r [*2] |-> mii_rx_r == MII_IDLE)
    else $error("receive path active in power-down");
  a_iso_quiet: assert property (
    mii_isolate_r [*2] |-> mii_rx_r == MII_IDLE)
    else $error("receive path active while isolated");
  a_loop_echo: assert property (
    loop_on ##1 loop_on |-> mii_rx_r == $past(mii_tx))
    else $error("loopback did not echo transmit data");
endmodule

bind pbmc_top pbmc_properties chk_u (
  .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .fiber_mode_enable,
  .power_down_pin_n, .mii_tx, .mii_rx_r, .phy_power_down_r,
  .mii_isolate_r, .loopback_active_r, .aneg_active_r, .core_reset_r
);

// ---- tb/pbmc_line_model.sv ----
`timescale 1ns/10ps
module pbmc_line_model
  import pbmc_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire pbmc_mii_t line_tx_r,
  output pbmc_mii_t      line_rx
);
  logic [3:0] spin_r = 4'h0;

  // echo sent nibbles inverted; idle carries a moving pattern
  // so a stale nibble can never pass for fresh data
  always_ff @(posedge sys_clk) begin
    spin_r <= spin_r + 4'h1;
    if (line_tx_r.valid)
      line_rx <= '{data: ~line_tx_r.data, valid: 1'b1};
    else
      line_rx <= '{data: spin_r, valid: 1'b0};
  end
endmodule

// ---- tb/pbmc_top_tb.sv ----
`timescale 1ns/10ps
module pbmc_top_tb
  import pbmc_pkg::*;
;
  logic              sys_clk, nrst, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata_r, v;
  logic              strap_speed_100, strap_full_duplex, strap_aneg_enable;
  logic              fiber_mode_enable, power_down_pin_n, aneg_speed_100;
  logic              aneg_full_duplex, link_up, fault_event, rx_error_event;
  pbmc_mii_t         mii_tx, mii_rx_r, line_rx, line_tx_r;
  logic              phy_power_down_r, mii_isolate_r, loopback_active_r;
  logic              link_speed_100_r, link_full_duplex_r, aneg_active_r;
  logic              core_reset_r;
  logic [15:0]       mode_v;
  int                mismatches, cmp_count, n;
  localparam int     LOOP_DEAD_CYC = 12500; // 500 us at 40 ns a cycle

  // effective mode as one word: negotiation, speed, duplex
  assign mode_v = 16'({aneg_active_r, link_speed_100_r, link_full_duplex_r});

  pbmc_top dut_u (
    .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_r, .strap_speed_100, .strap_full_duplex,
    .strap_aneg_enable, .fiber_mode_enable, .power_down_pin_n,
    .aneg_speed_100, .aneg_full_duplex, .link_up, .fault_event,
    .rx_error_event, .mii_tx, .mii_rx_r, .line_rx, .line_tx_r,
    .phy_power_down_r, .mii_isolate_r, .loopback_active_r,
    .link_speed_100_r, .link_full_duplex_r, .aneg_active_r, .core_reset_r
  );

  pbmc_line_model line_u (.sys_clk, .line_tx_r, .line_rx);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // strobes last one cycle and are launched just after an edge
  task automatic wr16(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd16(input logic [4:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_r;
  endtask

  task automatic rc(input logic [4:0] a, input logic [15:0] e);
    rd16(a);
    chk(v, e);
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask

  initial begin
    {nrst, reg_wr, reg_rd, fault_event, rx_error_event} = '0;
    {aneg_speed_100, strap_full_duplex, fiber_mode_enable} = '0;
    {strap_speed_100, strap_aneg_enable, aneg_full_duplex} = '1;
    {power_down_pin_n, link_up} = '1;
    reg_addr = '0;
    reg_wdata = '0;
    mii_tx = MII_IDLE;
    mismatches = 0;
    cmp_count = 0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    cyc(4);
    // strap defaults; auto-negotiation drives the effective mode
    rc(5'h00, 16'h3000);
    chk(mode_v, 16'h0005);
    // latched status bits and the permanent pattern
    rc(5'h01, 16'h4000);
    rc(5'h01, 16'h4004);
    @(posedge sys_clk) link_up <= 1'b0;
    @(posedge sys_clk) link_up <= 1'b1;
    rc(5'h01, 16'h4000);
    rc(5'h01, 16'h4004);
    @(posedge sys_clk) fault_event <= 1'b1;
    @(posedge sys_clk) fault_event <= 1'b0;
    rc(5'h01, 16'h4006);
    rc(5'h01, 16'h4004);
    wr16(5'h01, 16'hffff);
    rc(5'h01, 16'h4004);
    // three error cycles, then the counter empties on read
    @(posedge sys_clk) rx_error_event <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rx_error_event <= 1'b0;
    rc(5'h02, 16'h0003);
    rc(5'h02, 16'h0000);
    rc(5'h1f, 16'h0000);
    // manual speed and duplex, every combination, negotiation off
    for (n = 0; n < 4; n++) begin
      wr16(5'h00, {2'b00, n[1], 4'h0, n[0], 8'h00});
      cyc(2);
      chk(mode_v, 16'(n[1:0]));
      rc(5'h00, {2'b00, n[1], 4'h0, n[0], 8'h00});
    end
    wr16(5'h00, 16'h3100);
    cyc(2);
    chk(mode_v, 16'h0005);
    // as host, allow the receive path its dead time before trusting it
    @(posedge sys_clk) mii_tx <= '{data: 4'h5, valid: 1'b1};
    wr16(5'h00, 16'h4000);
    cyc(3);
    n = 0;
    while (mii_rx_r !== 5'h0b && n < LOOP_DEAD_CYC) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk({11'h0, mii_rx_r}, 16'h000b);
    chk({11'h0, line_tx_r}, 16'h0000);
    wr16(5'h00, 16'h0000);
    cyc(4);
    chk({11'h0, line_tx_r}, 16'h000b);
    chk({11'h0, mii_rx_r}, 16'h0015);
    wr16(5'h00, 16'h0400);
    cyc(3);
    chk({10'h0, mii_isolate_r, line_tx_r}, 16'h0020);
    rc(5'h00, 16'h0400);
    wr16(5'h00, 16'h0800);
    cyc(3);
    chk({10'h0, phy_power_down_r, mii_rx_r}, 16'h0020);
    rc(5'h00, 16'h0800);
    wr16(5'h00, 16'h0000);
    @(posedge sys_clk) power_down_pin_n <= 1'b0;
    cyc(3);
    chk(16'(phy_power_down_r), 16'h0001);
    rc(5'h00, 16'h0800);
    @(posedge sys_clk) power_down_pin_n <= 1'b1;
    wr16(5'h00, 16'h0000);
    cyc(2);
    chk(16'(phy_power_down_r), 16'h0000);
    // software reset with new straps; a write mid-run must not stop it
    @(posedge sys_clk);
    {strap_speed_100, strap_full_duplex, fiber_mode_enable} <= 3'b011;
    wr16(5'h00, 16'hc000);
    rd16(5'h00);
    chk(16'(v[15]), 16'h0001);
    wr16(5'h00, 16'h0000);
    rd16(5'h00);
    chk(16'(v[15]), 16'h0001);
    n = 0;
    while (core_reset_r === 1'b1 && n < 60) begin
      @(posedge sys_clk);
      #1 n++;
    end
    // a reset that never ends is a failure; the checks below then fail too
    if (n == 60) begin
      mismatches++;
    end
    cyc(2);
    rc(5'h00, 16'h0100);
    chk(mode_v, 16'h0001);
    chk(16'(loopback_active_r), 16'h0000);
    test_done();
  end
endmodule
